//--- hw/facr_bank.sv
// Fault qualification and alert mask configuration bank
// How it works
// - OV bit7=0: low-side switch stays off
// - OV bit7=1: low-side switch turns on
// - Fault after N+1 consecutive limit violations
// - Per-page config byte, resets to 00h
// - Report external temperature divided by gain
// - Per-page gain word, resets BA00h
// - Add per-page bias, resets 0000h
// - Words are mantissa times two^exponent
// - Masked faults never assert alert pin
// - Seven-byte mask, read/write, resets zero
// - Mask bit gates same status bit, except byte 5: status byte 5 never alerts
// - Mask byte 6 gates manufacturer faults
// - Mask byte 4 gates CML faults
// - Mask byte 3 gates temperature faults
// - Mask byte 2 gates input faults
// - Mask byte 1 gates output current faults
// - Mask byte 0 gates output voltage faults
module facr_bank (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // Command port from the bus engine
   input  wire logic        page_in,
   input  wire logic [7:0]  cmd_in,
   input  wire logic        wr_in,
   input  wire logic [2:0]  wr_idx_in,
   input  wire logic [7:0]  wr_data_in,
   input  wire logic        rd_in,
   input  wire logic [2:0]  rd_idx_in,
   // Voltage monitor per page
   input  wire logic [1:0]  vsample_in,
   input  wire logic [1:0]  ov_viol_in,
   input  wire logic [1:0]  uv_viol_in,
   // External temperature: one shared reading, start strobe per page
   input  wire logic [1:0]  temp_start_in,
   input  wire logic [15:0] remote_temp_input_in,
   // Status bytes
   input  wire logic [55:0] status_in,
   output logic [7:0]       rd_data_out,
   output logic             rd_hit_out,
   output logic [1:0]       ov_fault_out,
   output logic [1:0]       uv_fault_out,
   output logic [1:0]       lowside_on_out,
   output logic [1:0]       shutdown_out,
   output logic [1:0]       temp_valid_out,
   output logic [31:0]      temp_out,
   output logic             alert_output_pin_out
);
   logic [7:0]  vfq_cfg_q  [facr_pkg::NUM_PAGES];
   logic [15:0] ext_gain_q [facr_pkg::NUM_PAGES];
   logic [15:0] ext_bias_q [facr_pkg::NUM_PAGES];
   logic [55:0] alert_mask_q;
   logic [1:0]  ovf;
   logic [1:0]  uvf;
   logic [1:0]  tdone;
   logic [15:0] tval [facr_pkg::NUM_PAGES];
   logic [55:0] unmasked;
   logic [7:0]  rd_d;
   logic        hit_d;

   //------------------------------------------------------------
   // Register writes
   //------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int p = 0; p < facr_pkg::NUM_PAGES; p++) begin
            vfq_cfg_q[p]  <= facr_pkg::VFQ_CFG_RST;
            ext_gain_q[p] <= facr_pkg::EXT_GAIN_RST;
            ext_bias_q[p] <= facr_pkg::EXT_BIAS_RST;
         end
         alert_mask_q <= facr_pkg::ALERT_MASK_RST;
      end else if (wr_in) begin
         if (cmd_in == facr_pkg::CMD_VFQ_CFG) begin
            if (wr_idx_in < facr_pkg::LEN_VFQ) begin
               vfq_cfg_q[page_in] <= wr_data_in & facr_pkg::VFQ_WR_MASK;
            end
         end else if (cmd_in == facr_pkg::CMD_EXT_GAIN) begin
            if (wr_idx_in < facr_pkg::LEN_WORD) begin
               ext_gain_q[page_in][wr_idx_in[0]*8 +: 8] <= wr_data_in;
            end
         end else if (cmd_in == facr_pkg::CMD_EXT_BIAS) begin
            if (wr_idx_in < facr_pkg::LEN_WORD) begin
               ext_bias_q[page_in][wr_idx_in[0]*8 +: 8] <= wr_data_in;
            end
         end else if (cmd_in == facr_pkg::CMD_ALERT_MASK) begin
            if (wr_idx_in < facr_pkg::LEN_MASK) begin
               alert_mask_q[wr_idx_in*8 +: 8] <= wr_data_in;
            end
         end
      end
   end

   //------------------------------------------------------------
   // Register reads, low byte first
   //------------------------------------------------------------
   always_comb begin
      rd_d  = 8'h00;
      hit_d = 1'b0;
      if (cmd_in == facr_pkg::CMD_VFQ_CFG) begin
         hit_d = (rd_idx_in < facr_pkg::LEN_VFQ);
         rd_d  = hit_d ? vfq_cfg_q[page_in] : 8'h00;
      end else if (cmd_in == facr_pkg::CMD_EXT_GAIN) begin
         hit_d = (rd_idx_in < facr_pkg::LEN_WORD);
         rd_d  = hit_d ? ext_gain_q[page_in][rd_idx_in[0]*8 +: 8] : 8'h00;
      end else if (cmd_in == facr_pkg::CMD_EXT_BIAS) begin
         hit_d = (rd_idx_in < facr_pkg::LEN_WORD);
         rd_d  = hit_d ? ext_bias_q[page_in][rd_idx_in[0]*8 +: 8] : 8'h00;
      end else if (cmd_in == facr_pkg::CMD_ALERT_MASK) begin
         hit_d = (rd_idx_in < facr_pkg::LEN_MASK);
         rd_d  = hit_d ? alert_mask_q[rd_idx_in*8 +: 8] : 8'h00;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= 8'h00;
         rd_hit_out  <= 1'b0;
      end else begin
         rd_data_out <= rd_in ? rd_d : 8'h00;
         rd_hit_out  <= rd_in && hit_d;
      end
   end

   //------------------------------------------------------------
   // Per-page fault qualification and temperature calibration
   //------------------------------------------------------------
   for (genvar p = 0; p < facr_pkg::NUM_PAGES; p++) begin : g_page
      facr_viol_qual u_qual (
         .mclk_in      (mclk_in),
         .rst_n_in     (rst_n_in),
         .sample_in    (vsample_in[p]),
         .ov_in        (ov_viol_in[p]),
         .uv_in        (uv_viol_in[p]),
         .limit_in     (vfq_cfg_q[p][facr_pkg::VFQ_CNT_MSB:0]),
         .ov_fault_out (ovf[p]),
         .uv_fault_out (uvf[p])
      );
      facr_temp_cal u_temp (
         .mclk_in  (mclk_in),
         .rst_n_in (rst_n_in),
         .start_in (temp_start_in[p]),
         .temp_in  (remote_temp_input_in),
         .gain_in  (ext_gain_q[p]),
         .bias_in  (ext_bias_q[p]),
         .done_out (tdone[p]),
         .temp_out (tval[p])
      );
   end

   //------------------------------------------------------------
   // Fault response and low-side drive
   //------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ov_fault_out   <= 2'b00;
         uv_fault_out   <= 2'b00;
         shutdown_out   <= 2'b00;
         lowside_on_out <= 2'b00;
      end else begin
         ov_fault_out <= ovf;
         uv_fault_out <= uvf;
         for (int p = 0; p < facr_pkg::NUM_PAGES; p++) begin
            shutdown_out[p]   <= ovf[p] || uvf[p];
            lowside_on_out[p] <= ovf[p] && vfq_cfg_q[p][facr_pkg::VFQ_LS_ON_BIT];
         end
      end
   end

   //------------------------------------------------------------
   // Calibrated temperature outputs
   //------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         temp_out       <= 32'h0;
         temp_valid_out <= 2'b00;
      end else begin
         temp_valid_out <= tdone;
         for (int p = 0; p < facr_pkg::NUM_PAGES; p++) begin
            if (tdone[p]) begin
               temp_out[p*16 +: 16] <= tval[p];
            end
         end
      end
   end

   //------------------------------------------------------------
   // Alert gating
   //------------------------------------------------------------
   always_comb begin
      unmasked = status_in & ~alert_mask_q;
      unmasked[facr_pkg::ST_OTHER*8 +: 8] = 8'h00;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alert_output_pin_out <= 1'b0;
      end else begin
         alert_output_pin_out <= |unmasked;
      end
   end
endmodule

//--- common/facr_pkg.sv
// Constants and types shared by the fault and alert configuration bank
package facr_pkg;
   // Command codes of the bank
   localparam logic [7:0]  CMD_VFQ_CFG      = 8'hd8;
   localparam logic [7:0]  CMD_EXT_GAIN     = 8'hd9;
   localparam logic [7:0]  CMD_EXT_BIAS     = 8'hda;
   localparam logic [7:0]  CMD_ALERT_MASK   = 8'hdb;
   // Reset values
   localparam logic [7:0]  VFQ_CFG_RST      = 8'h00;
   localparam logic [15:0] EXT_GAIN_RST     = 16'hba00;
   localparam logic [15:0] EXT_BIAS_RST     = 16'h0000;
   localparam logic [55:0] ALERT_MASK_RST   = 56'h0000_0000_0000_00;
   // Field layout of the voltage fault configuration byte
   localparam int          VFQ_LS_ON_BIT    = 7;
   localparam int          VFQ_CNT_MSB      = 3;
   localparam int          VFQ_USED_MASK_W  = 8;
   localparam logic [7:0]  VFQ_WR_MASK      = 8'h8f;
   // Exponent and mantissa fields of a two-byte word
   localparam int          EXP_LSB          = 11;
   localparam int          MAN_MSB          = 10;
   // Output pages
   localparam int          NUM_PAGES        = 2;
   // Byte counts of each command
   localparam logic [2:0]  LEN_VFQ          = 3'h1;
   localparam logic [2:0]  LEN_WORD         = 3'h2;
   localparam logic [2:0]  LEN_MASK         = 3'h7;
   // Status byte indices
   localparam int          ST_VOUT          = 0;
   localparam int          ST_IOUT          = 1;
   localparam int          ST_INPUT         = 2;
   localparam int          ST_TEMP          = 3;
   localparam int          ST_CML           = 4;
   localparam int          ST_OTHER         = 5;
   localparam int          ST_MFR           = 6;
   localparam int          ST_BYTES         = 7;
   // Fixed point of the reported temperature (fraction bits)
   localparam int          TEMP_FRAC        = 8;
   typedef enum logic [1:0] {VIOL_NONE, VIOL_OV, VIOL_UV} facr_viol_t;
endpackage

//--- hw/facr_viol_qual.sv
// Consecutive-violation qualifier for one output page
module facr_viol_qual (
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic       sample_in,
   input  wire logic       ov_in,
   input  wire logic       uv_in,
   input  wire logic [3:0] limit_in,
   output logic            ov_fault_out,
   output logic            uv_fault_out
);
   logic [4:0] cnt_q;
   logic       last_ov_q;
   logic [4:0] prior_cnt;

   // A change between OV and UV makes this sample the first of a fresh run
   assign prior_cnt = (ov_in != last_ov_q) ? 5'h0 : cnt_q;

   // Count unbroken violations; a good sample clears the run
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q     <= 5'h0;
         last_ov_q <= 1'b0;
      end else if (sample_in) begin
         if (!(ov_in || uv_in)) begin
            cnt_q <= 5'h0;
         end else begin
            last_ov_q <= ov_in;
            if ((ov_in != last_ov_q) && (cnt_q != 5'h0)) begin
               cnt_q <= 5'h1;
            end else if (cnt_q <= {1'b0, limit_in}) begin
               cnt_q <= cnt_q + 5'h1;
            end
         end
      end
   end

   // Fault declared after N+1 violations in a row
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ov_fault_out <= 1'b0;
         uv_fault_out <= 1'b0;
      end else if (sample_in) begin
         ov_fault_out <= ov_in && (prior_cnt >= {1'b0, limit_in});
         uv_fault_out <= uv_in && !ov_in && (prior_cnt >= {1'b0, limit_in});
      end
   end
endmodule

//--- hw/facr_temp_cal.sv
// External temperature calibration: divide by gain, add bias
module facr_temp_cal (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        start_in,
   input  wire logic [15:0] temp_in,
   input  wire logic [15:0] gain_in,
   input  wire logic [15:0] bias_in,
   output logic             done_out,
   output logic [15:0]      temp_out
);
   // temp_in and temp_out are signed, 8 fraction bits
   logic        busy_q;
   logic [4:0]  step_q;
   logic [47:0] rem_q;
   logic [31:0] quo_q;
   logic [47:0] div_q;
   logic        neg_q;
   logic signed [31:0] bias_fx;
   logic signed [4:0]  bexp;
   logic signed [31:0] bman;

   // Bias in the same fixed point as the reading
   always_comb begin
      bexp = $signed(bias_in[15:facr_pkg::EXP_LSB]);
      bman = {{21{bias_in[facr_pkg::MAN_MSB]}}, bias_in[facr_pkg::MAN_MSB:0]};
      bias_fx = (bexp >= 0) ? (bman <<< (facr_pkg::TEMP_FRAC + bexp))
                            : (bman <<< facr_pkg::TEMP_FRAC) >>> (-bexp);
   end

   // Restoring divider: reading scaled by 1 / gain
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_q   <= 1'b0;
         step_q   <= 5'h0;
         rem_q    <= 48'h0;
         quo_q    <= 32'h0;
         div_q    <= 48'h0;
         neg_q    <= 1'b0;
         done_out <= 1'b0;
         temp_out <= 16'h0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_q) begin
            logic [15:0] mag;
            logic [10:0] gmag;
            logic signed [4:0] gexp;
            mag  = temp_in[15] ? 16'(-temp_in) : temp_in;
            gmag = gain_in[facr_pkg::MAN_MSB] ? 11'(-gain_in[10:0]) : gain_in[10:0];
            gexp = $signed(gain_in[15:facr_pkg::EXP_LSB]);
            neg_q <= temp_in[15] ^ gain_in[facr_pkg::MAN_MSB];
            // value/gain = mag*2^-e / m ; fold exponent into numerator
            rem_q <= (gexp >= 0) ? ({32'h0, mag} << 16) >> gexp
                                 : ({32'h0, mag} << 16) << (-gexp);
            div_q <= {37'h0, gmag};
            quo_q <= 32'h0;
            step_q <= 5'h0;
            busy_q <= (gmag != 11'h0);
         end else if (busy_q) begin
            // Shift-subtract one quotient bit per cycle
            if (rem_q >= (div_q << (5'd31 - step_q))) begin
               rem_q <= rem_q - (div_q << (5'd31 - step_q));
               quo_q[5'd31 - step_q] <= 1'b1;
            end
            step_q <= step_q + 5'h1;
            if (step_q == 5'd31) begin
               logic signed [31:0] q;
               q = neg_q ? -$signed(quo_q >> 16) : $signed(quo_q >> 16);
               busy_q   <= 1'b0;
               done_out <= 1'b1;
               temp_out <= 16'(q + bias_fx);
            end
         end
      end
   end
endmodule

//--- tb/facr_bank_sva.sv
// Port-level concurrent checks for the fault and alert configuration bank
module facr_bank_sva (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  cmd_in,
   input  wire logic        rd_in,
   input  wire logic [1:0]  vsample_in,
   input  wire logic [1:0]  ov_viol_in,
   input  wire logic [1:0]  uv_viol_in,
   input  wire logic [1:0]  temp_start_in,
   input  wire logic [55:0] status_in,
   input  wire logic [7:0]  rd_data_out,
   input  wire logic        rd_hit_out,
   input  wire logic [1:0]  ov_fault_out,
   input  wire logic [1:0]  uv_fault_out,
   input  wire logic [1:0]  lowside_on_out,
   input  wire logic [1:0]  shutdown_out,
   input  wire logic [1:0]  temp_valid_out,
   input  wire logic        alert_output_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_read_hit_cause: assert property (rd_hit_out |-> $past(rd_in) &&
      $past(cmd_in) >= 8'hd8 && $past(cmd_in) <= 8'hdb) else $error("read hit without read");
   a_idle_data_zero: assert property (!rd_hit_out |-> rd_data_out == 8'h00)
      else $error("read data not zero while idle");
   a_lowside_needs_ov: assert property (lowside_on_out[0] |-> ov_fault_out[0])
      else $error("low side on without over-voltage fault");
   a_ov_shuts_down: assert property (ov_fault_out[0] |-> shutdown_out[0])
      else $error("over-voltage fault without shutdown");
   a_shutdown_cause: assert property ($rose(shutdown_out[0]) |->
      ov_fault_out[0] || uv_fault_out[0]) else $error("shutdown without fault");
   a_fault_on_sample: assert property ($rose(ov_fault_out[0]) |->
      ($past(vsample_in[0]) && $past(ov_viol_in[0]))
      || ($past(vsample_in[0], 2) && $past(ov_viol_in[0], 2)))
      else $error("fault raised without violating sample");
   a_inlimit_clears: assert property (vsample_in[0] && !ov_viol_in[0] && !uv_viol_in[0]
      |-> ##[1:2] !ov_fault_out[0] && !uv_fault_out[0]) else $error("in-limit sample kept fault");
   a_alert_no_source: assert property ((status_in & 56'hff_00ff_ffff_ffff) == 56'h0
      |=> !alert_output_pin_out) else $error("alert without unmasked source");
   a_temp_latency: assert property (temp_valid_out[0] |-> $past(temp_start_in[0], 34))
      else $error("temperature result at wrong time");
   a_temp_pulse: assert property (temp_valid_out[0] |=> !temp_valid_out[0])
      else $error("temperature valid longer than one cycle");
endmodule

bind facr_bank facr_bank_sva u_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_in(cmd_in),
   .rd_in(rd_in), .vsample_in(vsample_in), .ov_viol_in(ov_viol_in), .uv_viol_in(uv_viol_in),
   .temp_start_in(temp_start_in), .status_in(status_in), .rd_data_out(rd_data_out),
   .rd_hit_out(rd_hit_out), .ov_fault_out(ov_fault_out), .uv_fault_out(uv_fault_out),
   .lowside_on_out(lowside_on_out), .shutdown_out(shutdown_out),
   .temp_valid_out(temp_valid_out), .alert_output_pin_out(alert_output_pin_out));

//--- tb/facr_host.sv
// Host model driving byte reads and writes on the command port
module facr_host (
   input  wire logic  mclk_in,
   output logic       page_out,
   output logic [7:0] cmd_out,
   output logic       wr_out,
   output logic [2:0] idx_out,
   output logic [7:0] data_out,
   output logic       rd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      page_out = 1'b0;
      cmd_out = 8'h00;
      wr_out = 1'b0;
      idx_out = 3'h0;
      data_out = 8'h00;
      rd_out = 1'b0;
   end
   // One strobe for a single cycle; data lines show garbage once released
   task automatic xfer(input logic pg, input logic [7:0] cmd, input logic [2:0] idx,
                       input logic [7:0] dat, input logic wr);
      @(negedge mclk_in);
      page_out = pg;
      cmd_out = cmd;
      idx_out = idx;
      data_out = dat;
      wr_out = wr;
      rd_out = !wr;
      @(negedge mclk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      data_out = ~dat;
   endtask
   // Exponent-mantissa word, low byte first
   task automatic wr_word(input logic pg, input logic [7:0] cmd, input logic [15:0] w);
      xfer(pg, cmd, 3'h0, w[7:0], 1'b1);
      xfer(pg, cmd, 3'h1, w[15:8], 1'b1);
   endtask
endmodule

//--- tb/test_facr_bank.sv
// Self-checking bench for the fault and alert configuration bank
module test_facr_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, page, wr, rd, rd_hit, alert;
   logic [7:0]  cmd, wdata, rd_data, s, m;
   logic [2:0]  idx;
   logic [1:0]  vsample, ov, uv, tstart, ov_f, uv_f, low_on, shut, tvalid;
   logic [15:0] rtemp, t;
   logic [55:0] status;
   logic [31:0] seed, temp_out;
   logic [7:0]  rq[$];
   logic [15:0] tq[$];
   int          miscompares, num_checks, cycles;
   facr_host host (.mclk_in(clk), .page_out(page), .cmd_out(cmd), .wr_out(wr),
                   .idx_out(idx), .data_out(wdata), .rd_out(rd));
   facr_bank dut (.mclk_in(clk), .rst_n_in(rst_n), .page_in(page), .cmd_in(cmd),
      .wr_in(wr), .wr_idx_in(idx), .wr_data_in(wdata), .rd_in(rd), .rd_idx_in(idx),
      .vsample_in(vsample), .ov_viol_in(ov), .uv_viol_in(uv), .temp_start_in(tstart),
      .remote_temp_input_in(rtemp), .status_in(status), .rd_data_out(rd_data),
      .rd_hit_out(rd_hit), .ov_fault_out(ov_f), .uv_fault_out(uv_f),
      .lowside_on_out(low_on), .shutdown_out(shut), .temp_valid_out(tvalid),
      .temp_out(temp_out), .alert_output_pin_out(alert));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic miss(input logic [15:0] got, input logic [15:0] exp);
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) miss({15'h0, got}, {15'h0, exp});
   endtask
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) miss({8'h00, got}, {8'h00, exp});
   endtask
   task automatic cmp_temp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic rd_exp(input logic pg, input logic [7:0] c, input logic [2:0] i,
                         input logic [7:0] exp);
      rq.push_back(exp);
      host.xfer(pg, c, i, 8'h00, 1'b0);
   endtask
   task automatic sample(input logic o, input logic u);
      @(negedge clk);
      vsample = 2'b01;
      ov = {1'b0, o};
      uv = {1'b0, u};
      @(negedge clk);
      vsample = 2'b00;
      ov = {1'b1, !o};
      uv = {1'b1, !u};
   endtask
   task automatic run_temp(input logic [15:0] v, input logic [15:0] exp);
      tq.push_back(exp);
      @(negedge clk);
      rtemp = v;
      tstart = 2'b01;
      @(negedge clk);
      tstart = 2'b00;
      for (int i = 0; i < 50 && tq.size() > 0; i++) @(negedge clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // Results are matched in order against the notes of the driver
   always @(negedge clk) begin
      if (rd_hit === 1'b1 && rq.size() > 0) cmp_rd(rd_data, rq.pop_front());
      else if (rd_hit === 1'b1) cmp_flag(1'b1, 1'b0);
      if (tvalid[0] === 1'b1 && tq.size() > 0) cmp_temp(temp_out[15:0], tq.pop_front());
      else if (tvalid[0] === 1'b1) cmp_flag(1'b1, 1'b0);
   end
   initial begin
      rst_n = 1'b0;
      {vsample, ov, uv, tstart, rtemp, status} = '0;
      seed = 32'h0000_2d6d;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      for (int p = 0; p < 2; p++) begin
         rd_exp(p[0], facr_pkg::CMD_VFQ_CFG, 3'h0, facr_pkg::VFQ_CFG_RST);
         rd_exp(p[0], facr_pkg::CMD_EXT_GAIN, 3'h0, facr_pkg::EXT_GAIN_RST[7:0]);
         rd_exp(p[0], facr_pkg::CMD_EXT_GAIN, 3'h1, facr_pkg::EXT_GAIN_RST[15:8]);
         rd_exp(p[0], facr_pkg::CMD_EXT_BIAS, 3'h1, facr_pkg::EXT_BIAS_RST[15:8]);
      end
      for (int k = 0; k < 7; k++)
         rd_exp(1'b0, facr_pkg::CMD_ALERT_MASK, k[2:0], 8'h00);
      host.xfer(1'b0, 8'hdc, 3'h0, 8'h00, 1'b0);
      host.xfer(1'b1, facr_pkg::CMD_VFQ_CFG, 3'h0, 8'hff, 1'b1);
      rd_exp(1'b1, facr_pkg::CMD_VFQ_CFG, 3'h0, 8'h8f);
      rd_exp(1'b0, facr_pkg::CMD_VFQ_CFG, 3'h0, 8'h00);
      $display("test registers done");
      for (int k = 0; k < 7; k++) begin
         seed = lfsr(seed);
         s = seed[15:8] | 8'h01;
         m = seed[7:0];
         @(negedge clk) status = {48'h0, s} << (8 * k);
         host.xfer(1'b0, facr_pkg::CMD_ALERT_MASK, k[2:0], s, 1'b1);
         repeat (2) @(negedge clk);
         cmp_flag(alert, 1'b0);
         host.xfer(1'b0, facr_pkg::CMD_ALERT_MASK, k[2:0], m, 1'b1);
         rd_exp(1'b0, facr_pkg::CMD_ALERT_MASK, k[2:0], m);
         cmp_flag(alert, k != 5 && |(s & ~m));
      end
      $display("test alert mask done");
      host.xfer(1'b0, facr_pkg::CMD_VFQ_CFG, 3'h0, 8'h82, 1'b1);
      repeat (2) sample(1'b1, 1'b0);
      sample(1'b0, 1'b0);
      repeat (2) sample(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      cmp_flag(ov_f[0], 1'b0);
      sample(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      cmp_flag(ov_f[0], 1'b1);
      cmp_flag(low_on[0], 1'b1);
      cmp_flag(shut[0], 1'b1);
      host.xfer(1'b0, facr_pkg::CMD_VFQ_CFG, 3'h0, 8'h00, 1'b1);
      sample(1'b0, 1'b0);
      sample(1'b0, 1'b1);
      repeat (3) @(negedge clk);
      cmp_flag(uv_f[0], 1'b1);
      sample(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      cmp_flag(ov_f[0], 1'b1);
      cmp_flag(low_on[0], 1'b0);
      // Page 1 still holds 8f: sixteen violations, low side on
      for (int i = 0; i < 16; i++) begin
         if (i == 15) cmp_flag(ov_f[1], 1'b0);
         @(negedge clk);
         vsample = 2'b10;
         ov = 2'b10;
         uv = 2'b00;
         @(negedge clk);
         vsample = 2'b00;
      end
      repeat (2) @(negedge clk);
      cmp_flag(ov_f[1] && shut[1] && low_on[1], 1'b1);
      $display("test fault qualification done");
      run_temp(16'h1900, 16'h1900);
      host.wr_word(1'b0, facr_pkg::CMD_EXT_GAIN, 16'hc200);
      host.wr_word(1'b0, facr_pkg::CMD_EXT_BIAS, 16'h0005);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         t = {1'b0, seed[14:0]};
         run_temp(t, (t >> 1) + 16'h0500);
      end
      $display("test temperature done");
      repeat (4) @(negedge clk);
      cmp_flag(rq.size() == 0 && tq.size() == 0, 1'b1);
      give_verdict();
   end
endmodule
